// *** lcd_defs.svh ***
// Offsets, field positions, reset values and timing counts.
// Assumes inclusion by its bare name from the package and the testbench.
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// ----------------
// Register byte offsets
// ----------------
`define LCD_OFS_CTRL     8'h00
`define LCD_OFS_DWELL    8'h04
`define LCD_OFS_STATUS   8'h08
`define LCD_OFS_INTSTAT  8'h0C
`define LCD_OFS_INTMASK  8'h10

// ----------------
// Field positions
// ----------------
`define LCD_CTRL_GOODS   0
`define LCD_CTRL_ENABLE  1
`define LCD_ST_FLOOR_LSB 0
`define LCD_ST_STATE_LSB 4
`define LCD_ST_OVERLOAD  8
`define LCD_ST_LOCKED    9
`define LCD_ST_ZONE      10
`define LCD_ST_CALLS_LSB 16
`define LCD_INT_ACCEPT   0
`define LCD_INT_ARRIVE   1
`define LCD_INT_REOPEN   2
`define LCD_INT_OVERLOAD 3
`define LCD_INT_BITS     4

// ----------------
// Reset values and timing
// ----------------
`define LCD_CTRL_RESET   2'h0
`define LCD_MASK_RESET   4'h0
`define LCD_DWELL_MS     5000
`define LCD_CLK_KHZ      20000
`define LCD_DWELL_CYCLES (`LCD_DWELL_MS * `LCD_CLK_KHZ)
`define LCD_RESP_OKAY    2'h0
`define LCD_RESP_SLVERR  2'h2

`endif

// *** lcd_pkg.sv ***
// Types shared by the lift call and door controller modules.
// Assumes lcd_defs.svh is on the include path.
`default_nettype none

package lcd_pkg;
    `include "lcd_defs.svh"

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CLOSE  = 3'b001,
        ST_REOPEN = 3'b010,
        ST_START  = 3'b011,
        ST_RUN    = 3'b100,
        ST_OPEN   = 3'b101,
        ST_DWELL  = 3'b110
    } lcd_state_type;
endpackage

`default_nettype wire

// *** lcd_dwell_timer.sv ***
// Door dwell timer: counts a loaded number of clock cycles and pulses
// expired for one cycle when the count runs out.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module lcd_dwell_timer
    import lcd_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    input  wire logic         abort,
    output logic              expired,
    output logic              running
);
    logic [W-1:0] count;

    // ----------------
    // Counter
    // ----------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (load) begin
                // A zero load still waits one cycle before expiring.
                count   <= (loadValue == '0) ? W'(1) : loadValue;
                running <= 1'b1;
            end else if (running) begin
                if (count == W'(1)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                count <= count - W'(1);
            end
        end
    end
endmodule

`default_nettype wire

// *** lift_call_door_controller.sv ***
// Lift call registration, door sequencing and start interlock for a
// call-and-send dumbwaiter or a single-button goods lift.
// Assumes synchronous pin inputs, one 20 MHz clock and an AXI4-Lite
// master that keeps at most one write and one read under way.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`default_nettype none

module lift_call_door_controller
    import lcd_pkg::*;
#(
    parameter int          FLOORS       = 4,
    parameter logic [31:0] DWELL_CYCLES = 32'(`LCD_DWELL_CYCLES)
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [FLOORS-1:0] landingBtn,
    input  wire logic [FLOORS-1:0] carBtn,
    input  wire logic              doorCloseBtn,
    input  wire logic [FLOORS-1:0] atFloor,
    input  wire logic              inUnlockZone,
    input  wire logic              carDoorLocked,
    input  wire logic [FLOORS-1:0] landingDoorLocked,
    input  wire logic              doorsFullyOpen,
    input  wire logic              safetyEdge,
    input  wire logic              overload,
    output logic [FLOORS-1:0]      callLamp,
    output logic                   inUseLamp,
    output logic [FLOORS-1:0]      buzzer,
    output logic                   doorOpenCmd,
    output logic                   doorCloseCmd,
    output logic                   driveRun,
    output logic                   driveUp,
    output logic                   carDoorLockCmd,
    output logic                   alarmSound,
    output logic                   alarmLamp,
    output logic                   irq
);
    localparam int FW = (FLOORS > 1) ? $clog2(FLOORS) : 1;

    lcd_state_type          state;
    lcd_state_type          next_state;
    logic [1:0]             ctrl;
    logic [31:0]            dwell;
    logic [`LCD_INT_BITS-1:0] intStat;
    logic [`LCD_INT_BITS-1:0] intMask;
    logic [FLOORS-1:0]      calls;
    logic [FLOORS-1:0]      next_calls;
    logic [FW-1:0]          carFloor;
    logic [FW-1:0]          target;
    logic                   overloadQ;
    logic                   dwellLoad;
    logic                   dwellExpired;
    logic                   awTaken;
    logic                   wTaken;
    logic [7:0]             awAddr;
    logic [31:0]            wData;
    logic [3:0]             wStrb;

    // ----------------
    // Derived conditions
    // ----------------
    logic              goods;
    logic              enable;
    logic              allLocked;
    logic              inZone;
    logic [FLOORS-1:0] hereMask;
    logic [FLOORS-1:0] setMask;
    logic [FLOORS-1:0] elsewhere;
    logic              arrive;
    logic              hereCall;
    logic              carPress;
    logic [FW-1:0]     pick;
    logic [FW-1:0]     zoneFloor;

    assign goods     = ctrl[`LCD_CTRL_GOODS];
    assign enable    = ctrl[`LCD_CTRL_ENABLE];
    assign allLocked = carDoorLocked & (&landingDoorLocked);
    assign inZone    = |atFloor;
    assign elsewhere = calls & ~hereMask;
    assign arrive    = (state == ST_RUN) && atFloor[target];
    assign hereCall  = goods && inZone && |(landingBtn & atFloor);
    assign carPress  = goods && (|carBtn || doorCloseBtn);

    always_comb begin
        hereMask = '0;
        pick     = '0;
        zoneFloor = carFloor;
        for (int i = FLOORS - 1; i >= 0; i--) begin
            if (FW'(i) == carFloor)
                hereMask[i] = 1'b1;
            if (elsewhere[i])
                pick = FW'(i);
            if (atFloor[i])
                zoneFloor = FW'(i);
        end
    end

    // Calls for the floor the car stands at are not registered: in goods
    // mode such a landing press reopens the doors instead.
    always_comb begin
        setMask = landingBtn;
        if (goods)
            setMask = landingBtn | carBtn;
        if (state != ST_RUN && inZone)
            setMask = setMask & ~atFloor;
        if (!enable)
            setMask = '0;
        next_calls = calls | setMask;
        if (arrive)
            next_calls[target] = 1'b0;
    end

    // ----------------
    // Sequencer
    // ----------------
    always_comb begin
        next_state = state;
        dwellLoad  = 1'b0;
        case (state)
            ST_IDLE:
                if (!enable)
                    next_state = ST_IDLE;
                else if (!goods) begin
                    if (|elsewhere && allLocked && !overload)
                        next_state = ST_RUN;
                end else if (hereCall)
                    next_state = ST_OPEN;
                else if (|elsewhere || carPress)
                    next_state = ST_CLOSE;
            ST_CLOSE:
                if (hereCall)
                    next_state = ST_OPEN;
                else if (safetyEdge)
                    next_state = ST_REOPEN;
                else if (allLocked)
                    next_state = ST_START;
            ST_REOPEN:
                if (doorsFullyOpen)
                    next_state = ST_CLOSE;
            ST_START:
                if (hereCall)
                    next_state = ST_OPEN;
                else if (!(|elsewhere))
                    next_state = ST_IDLE;
                else if (!allLocked)
                    next_state = ST_CLOSE;
                else if (!overload)
                    next_state = ST_RUN;
            ST_RUN:
                if (arrive)
                    next_state = goods ? ST_OPEN : ST_IDLE;
            ST_OPEN:
                if (doorsFullyOpen) begin
                    next_state = ST_DWELL;
                    dwellLoad  = 1'b1;
                end
            ST_DWELL:
                if (carPress || dwellExpired)
                    next_state = ST_CLOSE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    lcd_dwell_timer #(
        .W(32)
    ) u_dwell (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (dwellLoad),
        .loadValue(dwell),
        .abort    (state == ST_DWELL && carPress),
        .expired  (dwellExpired),
        .running  ()
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state    <= ST_IDLE;
            calls    <= '0;
            carFloor <= '0;
            target   <= '0;
        end else begin
            state    <= next_state;
            calls    <= next_calls;
            carFloor <= zoneFloor;
            if (next_state == ST_RUN && state != ST_RUN)
                target <= pick;
        end
    end

    // ----------------
    // Registered outputs
    // ----------------
    assign callLamp = calls;

    // The in-use lamp follows the next call value so that it turns
    // on at the very edge at which the call is taken.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inUseLamp      <= 1'b0;
            buzzer         <= '0;
            doorOpenCmd    <= 1'b0;
            doorCloseCmd   <= 1'b0;
            driveRun       <= 1'b0;
            driveUp        <= 1'b0;
            carDoorLockCmd <= 1'b1;
            alarmSound     <= 1'b0;
            alarmLamp      <= 1'b0;
        end else begin
            inUseLamp <= |next_calls || next_state != ST_IDLE;
            buzzer    <= '0;
            if (!goods && state == ST_IDLE && |elsewhere)
                buzzer <= hereMask;
            doorOpenCmd  <= next_state == ST_OPEN ||
                            next_state == ST_REOPEN;
            doorCloseCmd <= next_state == ST_CLOSE;
            driveRun     <= next_state == ST_RUN && allLocked;
            driveUp      <= (next_state == ST_RUN && state != ST_RUN)
                            ? (pick > carFloor) : (target > carFloor);
            carDoorLockCmd <= !inUnlockZone;
            alarmSound     <= overload;
            alarmLamp      <= overload;
        end
    end

    // ----------------
    // Register bus
    // ----------------
    logic        wrFire;
    logic        rdFire;
    logic [31:0] statusWord;
    logic [`LCD_INT_BITS-1:0] events;

    assign wrFire = awTaken && wTaken && !s_axi_bvalid;
    assign rdFire = s_axi_arvalid && s_axi_arready;

    always_comb begin
        statusWord = '0;
        for (int i = 0; i < FW && i < 4; i++)
            statusWord[`LCD_ST_FLOOR_LSB + i] = carFloor[i];
        for (int i = 0; i < 3; i++)
            statusWord[`LCD_ST_STATE_LSB + i] = state[i];
        statusWord[`LCD_ST_OVERLOAD] = overload;
        statusWord[`LCD_ST_LOCKED]   = allLocked;
        statusWord[`LCD_ST_ZONE]     = inUnlockZone;
        for (int i = 0; i < FLOORS && i < 16; i++)
            statusWord[`LCD_ST_CALLS_LSB + i] = calls[i];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awTaken       <= 1'b0;
            wTaken        <= 1'b0;
            awAddr        <= '0;
            wData         <= '0;
            wStrb         <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LCD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken       <= 1'b1;
                awAddr        <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wTaken       <= 1'b1;
                wData        <= s_axi_wdata;
                wStrb        <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr == `LCD_OFS_CTRL ||
                                 awAddr == `LCD_OFS_DWELL ||
                                 awAddr == `LCD_OFS_INTMASK)
                                ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                awTaken       <= 1'b0;
                wTaken        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write strobes are honoured per byte only for the dwell count; the
    // narrow control registers live in byte lane 0.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl    <= `LCD_CTRL_RESET;
            dwell   <= DWELL_CYCLES;
            intMask <= `LCD_MASK_RESET;
        end else if (wrFire) begin
            if (awAddr == `LCD_OFS_CTRL && wStrb[0])
                ctrl <= wData[1:0];
            else if (awAddr == `LCD_OFS_DWELL) begin
                for (int b = 0; b < 4; b++)
                    if (wStrb[b])
                        dwell[8*b +: 8] <= wData[8*b +: 8];
            end else if (awAddr == `LCD_OFS_INTMASK && wStrb[0])
                intMask <= wData[`LCD_INT_BITS-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `LCD_RESP_OKAY;
        end else begin
            if (rdFire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `LCD_RESP_OKAY;
                if (s_axi_araddr == `LCD_OFS_CTRL) begin
                    s_axi_rdata <= {30'h0, ctrl};
                end else if (s_axi_araddr == `LCD_OFS_DWELL) begin
                    s_axi_rdata <= dwell;
                end else if (s_axi_araddr == `LCD_OFS_STATUS) begin
                    s_axi_rdata <= statusWord;
                end else if (s_axi_araddr == `LCD_OFS_INTSTAT) begin
                    s_axi_rdata <= {28'h0, intStat};
                end else if (s_axi_araddr == `LCD_OFS_INTMASK) begin
                    s_axi_rdata <= {28'h0, intMask};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `LCD_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------
    // Interrupts
    // ----------------
    always_comb begin
        events = '0;
        events[`LCD_INT_ACCEPT]   = |(setMask & ~calls);
        events[`LCD_INT_ARRIVE]   = arrive;
        events[`LCD_INT_REOPEN]   = state == ST_CLOSE && safetyEdge &&
                                    !hereCall;
        events[`LCD_INT_OVERLOAD] = overload && !overloadQ;
    end

    // A read clears the sticky bits, but an event in the same cycle is
    // kept so that it cannot slip between the read and the clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            intStat   <= '0;
            overloadQ <= 1'b0;
            irq       <= 1'b0;
        end else begin
            overloadQ <= overload;
            if (rdFire && s_axi_araddr == `LCD_OFS_INTSTAT)
                intStat <= events;
            else
                intStat <= intStat | events;
            irq <= |((intStat | events) & intMask) &&
                   !(rdFire && s_axi_araddr == `LCD_OFS_INTSTAT &&
                     !(|(events & intMask)));
        end
    end
endmodule

`default_nettype wire

// *** lcd_partner.sv ***
// Far-side model: door operator, door locks and a car that moves one floor
// per eight cycles of drive. Assumes the controller's clock.
`default_nettype none

module lcd_partner #(
    parameter int FLOORS = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              doorOpenCmd,
    input  wire logic              doorCloseCmd,
    input  wire logic              driveRun,
    input  wire logic              driveUp,
    input  wire logic              manualOpen,
    output logic [FLOORS-1:0]      atFloor,
    output logic                   inUnlockZone,
    output var logic               carDoorLocked = 1'b1,
    output logic [FLOORS-1:0]      landingDoorLocked,
    output logic                   doorsFullyOpen
);
    int pos = 0;
    int floorNo = 0;
    int trip = 0;
    bit byHand = 0;

    // A lock engages one cycle after the panels meet, never while pushed.
    always @(posedge clk_sys) begin
        if (manualOpen || doorOpenCmd) begin
            pos <= (pos < 3) ? pos + 1 : 3;
        end else if ((doorCloseCmd || byHand) && pos > 0) begin
            pos <= pos - 1;
        end
        carDoorLocked <= pos == 0 && !manualOpen && !doorOpenCmd;
        byHand <= manualOpen || (byHand && pos > 1);
        trip <= (driveRun && trip < 7) ? trip + 1 : 0;
        if (driveRun && trip == 7) begin
            floorNo <= driveUp ? floorNo + 1 : floorNo - 1;
        end
    end
    assign landingDoorLocked = {FLOORS{carDoorLocked}};
    assign doorsFullyOpen    = pos == 3;
    assign inUnlockZone      = trip < 2;
    assign atFloor = inUnlockZone ? FLOORS'(1) << floorNo : '0;
endmodule

`default_nettype wire

// *** lcd_assertions.sv ***
// Checker on the controller's lamp, door and drive pins.
// Assumes binding into lift_call_door_controller; names match its ports.
`default_nettype none

module lcd_assertions #(
    parameter int F = 4
) (
    input wire logic         clk_sys,
    input wire logic         rst,
    input wire logic         overload,
    input wire logic         alarmSound,
    input wire logic         alarmLamp,
    input wire logic         driveRun,
    input wire logic         carDoorLocked,
    input wire logic [F-1:0] landingDoorLocked,
    input wire logic         inUnlockZone,
    input wire logic         carDoorLockCmd,
    input wire logic [F-1:0] callLamp,
    input wire logic [F-1:0] atFloor,
    input wire logic         inUseLamp,
    input wire logic [F-1:0] buzzer,
    input wire logic         doorOpenCmd,
    input wire logic         doorCloseCmd,
    input wire logic         safetyEdge
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_closing;
        doorCloseCmd && !carDoorLocked && safetyEdge;
    endsequence
    sequence s_reopen;
        ##[1:3] doorOpenCmd;
    endsequence

    property p_reopen; s_closing |-> s_reopen; endproperty
    property p_alarm;
        1 |=> alarmSound == $past(overload) && alarmLamp == $past(overload);
    endproperty
    property p_lock; 1 |=> carDoorLockCmd == !$past(inUnlockZone); endproperty
    property p_start;
        $rose(driveRun) |-> $past(carDoorLocked && &landingDoorLocked);
    endproperty
    // Three cycles cover the state lag between a start and driveRun.
    property p_ovl; overload [*3] ##0 !driveRun |=> !driveRun; endproperty
    property p_inuse; |callLamp |-> inUseLamp; endproperty
    property p_cancel;
        1 |=> ($past(callLamp) & ~callLamp & ~$past(atFloor)) == '0;
    endproperty
    property p_buzz;
        |buzzer |-> $onehot(buzzer) && (buzzer & atFloor) == buzzer;
    endproperty
    property p_runshut; driveRun |-> !doorOpenCmd; endproperty

    a_reopen: assert property (p_reopen) else $error("no reopen");
    a_alarm: assert property (p_alarm) else $error("alarm lag");
    a_lock: assert property (p_lock) else $error("door lock");
    a_start: assert property (p_start) else $error("start unlocked");
    a_ovl: assert property (p_ovl) else $error("overload start");
    a_inuse: assert property (p_inuse) else $error("in use off");
    a_cancel: assert property (p_cancel) else $error("lamp lost");
    a_buzz: assert property (p_buzz) else $error("buzzer floor");
    a_runshut: assert property (p_runshut) else $error("run open");
endmodule

bind lift_call_door_controller lcd_assertions #(.F(FLOORS))
    lcd_assertions_inst (.*);

`default_nettype wire

// *** lift_call_door_controller_tb.sv ***
// Self-checking bench: registers, goods trips, overload, call-and-send.
// Assumes lcd_partner plays doors and drive; car starts at floor 0.
`default_nettype none
`include "lcd_defs.svh"

module lift_call_door_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int F = 4;
    localparam int RUN = 0, OPN = 1, CLS = 2, FOP = 3, ALM = 4;
    logic              clk_sys = 0, rst = 1, manualOpen = 0;
    logic [7:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic              s_axi_arvalid = 0, s_axi_rready = 0;
    logic [F-1:0]      landingBtn = '0, carBtn = '0;
    logic              doorCloseBtn = 0, safetyEdge = 0, overload = 0;
    wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, irq;
    wire logic         s_axi_arready, s_axi_rvalid, alarmSound, alarmLamp;
    wire logic [1:0]   s_axi_bresp, s_axi_rresp;
    wire logic [31:0]  s_axi_rdata;
    wire logic [F-1:0] atFloor, landingDoorLocked, callLamp, buzzer;
    wire logic         inUnlockZone, carDoorLocked, doorsFullyOpen, inUseLamp;
    wire logic         doorOpenCmd, doorCloseCmd, driveRun, driveUp;
    wire logic         carDoorLockCmd;
    wire logic [4:0]   mon = {alarmSound, doorsFullyOpen, doorCloseCmd,
                              doorOpenCmd, driveRun};
    int                n_errors = 0, checks_done = 0, k;

    always #25 clk_sys = ~clk_sys;

    lift_call_door_controller #(.FLOORS(F), .DWELL_CYCLES(32'h14))
        lift_call_door_controller_inst (.*);
    lcd_partner #(.FLOORS(F)) lcd_partner_inst (.*);

    // ----------------
    // Shared checks, waits and bus cycles
    // ----------------
    task automatic tally_and_finish;
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bound(input int lim);
        if (k == lim) begin
            chk(0, 1);
            tally_and_finish();
        end
    endtask
    // Leaves k holding the number of edges spent waiting.
    task automatic wait_on(input int s, input logic v);
        for (k = 0; k < 3000 && mon[s] !== v; k++) @(posedge clk_sys);
        bound(3000);
    endtask
    task automatic press(input logic [F-1:0] lb, cb, input logic dc);
        landingBtn <= lb;
        carBtn <= cb;
        doorCloseBtn <= dc;
        @(posedge clk_sys);
        {landingBtn, carBtn, doorCloseBtn} <= '0;
        @(posedge clk_sys);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid === 1) break;
        end
        s_axi_bready <= 0;
        @(posedge clk_sys);
        bound(50);
        chk(s_axi_bresp, er);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, m,
                          input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid === 1) break;
        end
        s_axi_rready <= 0;
        @(posedge clk_sys);
        bound(50);
        chk(s_axi_rdata & m, ed);
        chk(s_axi_rresp, er);
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs;
        axi_rd(`LCD_OFS_CTRL, 0, '1, `LCD_RESP_OKAY);
        axi_wr(8'h14, 1, `LCD_RESP_SLVERR);
        axi_wr(`LCD_OFS_STATUS, 1, `LCD_RESP_SLVERR);
        axi_rd(8'h14, 0, '1, `LCD_RESP_SLVERR);
        axi_wr(`LCD_OFS_DWELL, 32'h18, `LCD_RESP_OKAY);
        axi_rd(`LCD_OFS_DWELL, 32'h18, '1, `LCD_RESP_OKAY);
        axi_wr(`LCD_OFS_CTRL, 32'h3, `LCD_RESP_OKAY);
    endtask
    task automatic t_goods_trip;
        press(4'h4, 0, 0);
        chk(callLamp, 4'h4);
        chk(inUseLamp, 1);
        wait_on(RUN, 1);
        chk(driveUp, 1);
        wait_on(OPN, 1);
        chk(callLamp, 0);
        chk(atFloor, 4'h4);
        wait_on(FOP, 1);
        wait_on(CLS, 1);
        chk(k >= 24 && k <= 30, 1);
    endtask
    task automatic t_here_and_edge;
        repeat (10) @(posedge clk_sys);
        press(4'h4, 0, 0);
        wait_on(OPN, 1);
        chk(callLamp, 0);
        wait_on(FOP, 1);
        press(0, 4'h1, 0);
        chk(callLamp, 4'h1);
        wait_on(CLS, 1);
        chk(k <= 2, 1);
        safetyEdge <= 1;
        @(posedge clk_sys);
        safetyEdge <= 0;
        wait_on(OPN, 1);
        chk(k <= 3, 1);
        wait_on(CLS, 1);
        wait_on(RUN, 1);
        chk(driveUp, 0);
        wait_on(OPN, 1);
        chk(atFloor, 4'h1);
    endtask
    task automatic t_overload;
        wait_on(FOP, 1);
        axi_wr(`LCD_OFS_INTMASK, 0, `LCD_RESP_OKAY);
        overload <= 1;
        press(0, 4'h8, 1);
        wait_on(ALM, 1);
        chk(alarmLamp, 1);
        repeat (40) @(posedge clk_sys);
        chk(driveRun, 0);
        chk(irq, 0);
        axi_wr(`LCD_OFS_INTMASK, 32'h8, `LCD_RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1);
        axi_rd(`LCD_OFS_INTSTAT, 32'h8, 32'h8, `LCD_RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
        overload <= 0;
        wait_on(RUN, 1);
        wait_on(OPN, 1);
        chk(atFloor, 4'h8);
    endtask
    task automatic t_callsend;
        wait_on(FOP, 1);
        wait_on(CLS, 1);
        repeat (10) @(posedge clk_sys);
        axi_wr(`LCD_OFS_CTRL, 32'h2, `LCD_RESP_OKAY);
        manualOpen <= 1;
        repeat (6) @(posedge clk_sys);
        press(4'h2, 0, 0);
        chk(callLamp, 4'h2);
        chk(inUseLamp, 1);
        repeat (20) @(posedge clk_sys);
        chk(buzzer, 4'h8);
        chk(driveRun, 0);
        manualOpen <= 0;
        wait_on(RUN, 1);
        chk(driveUp, 0);
        wait_on(RUN, 0);
        chk(callLamp, 0);
        chk(atFloor, 4'h2);
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        t_regs();
        t_goods_trip();
        t_here_and_edge();
        t_overload();
        t_callsend();
        tally_and_finish();
    end
endmodule

`default_nettype wire
